// ---- shared/lim_pkg.sv ----
// Types and constants shared by the load limit and status logic.
// Assumes one clock, a synchronous reset and host text commands already parsed into words.
package lim_pkg;
  localparam int DATA_W = 16;
  localparam int DUTY_W = 7;
  localparam int ERROR_W = 6;
  localparam int PROTECTION_FLAGS_W = 4;
  localparam int LIMIT_N = 4;
  localparam logic [DATA_W-1:0] LIMIT_UPPER_RESET = 16'hFFFF;
  localparam logic [DATA_W-1:0] LIMIT_LOWER_RESET = 16'h0000;
  // Duty is held in hundredths.
  localparam logic [DUTY_W-1:0] DUTY_MIN = 7'h01;
  localparam logic [DUTY_W-1:0] DUTY_MAX = 7'h63;
  localparam logic [DUTY_W-1:0] DUTY_RESET = 7'h32;
  localparam logic [DATA_W-1:0] DIMMING_FREQUENCY_DC = 16'h0000;
  localparam logic [DATA_W-1:0] DIMMING_FREQUENCY_RESET = 16'h0000;
  // Current below this word selects the precise range under automatic ranging.
  localparam logic [DATA_W-1:0] RANGE_PRECISE_BELOW = 16'h1000;
  localparam int ERR_OPERATION_BIT = 4;
  localparam int ERR_COMMAND_BIT = 5;
  localparam int PROTECTION_FLAGS_POWER_BIT = 0;
  localparam int PROTECTION_FLAGS_TEMPERATURE_BIT = 1;
  localparam int PROTECTION_FLAGS_VOLTAGE_BIT = 2;
  localparam int PROTECTION_FLAGS_CURRENT_BIT = 3;

  typedef enum logic [2:0] {
    MODE_CONSTANT_CURRENT    = 3'h0,
    MODE_CONSTANT_RESISTANCE = 3'h1,
    MODE_CONSTANT_VOLTAGE    = 3'h2,
    MODE_CONSTANT_POWER      = 3'h3,
    MODE_LED_SIMULATION      = 3'h4
  } mode_t;

  typedef enum logic [1:0] {
    SENSE_OFF  = 2'h0,
    SENSE_ON   = 2'h1,
    SENSE_AUTO = 2'h2
  } sense_t;

  typedef enum logic [1:0] {
    LIM_CURRENT       = 2'h0,
    LIM_POWER         = 2'h1,
    LIM_VOLTAGE       = 2'h2,
    LIM_SHORT_VOLTAGE = 2'h3
  } limit_sel_t;

  typedef enum logic [4:0] {
    OP_SET_LOAD, OP_SET_MODE, OP_SET_SHORT, OP_SET_PRESET, OP_SET_SENSE,
    OP_SET_LEVEL, OP_SET_DYNAMIC, OP_SET_RANGE, OP_SET_FREQUENCY, OP_SET_DUTY,
    OP_SET_UPPER, OP_SET_LOWER, OP_CLEAR,
    OP_GET_LOAD, OP_GET_MODE, OP_GET_SHORT, OP_GET_PRESET, OP_GET_SENSE,
    OP_GET_LEVEL, OP_GET_DYNAMIC, OP_GET_FREQUENCY, OP_GET_DUTY,
    OP_GET_UPPER, OP_GET_LOWER, OP_GET_ERROR, OP_GET_PROTECTION, OP_GET_NO_GOOD
  } op_t;

  typedef struct packed {
    logic              valid;
    op_t               op;
    limit_sel_t        sel;
    logic [DATA_W-1:0] value;
  } cmd_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] current;
    logic [DATA_W-1:0] power;
    logic [DATA_W-1:0] voltage;
  } meas_t;

  typedef struct packed {
    logic              valid;
    logic              refused;
    logic [DATA_W-1:0] data;
  } rsp_t;

  function automatic logic isOp(input cmd_t c, input op_t o);
    return c.valid && (c.op == o);
  endfunction : isOp

  function automatic logic [DATA_W-1:0] bitWord(input logic b);
    return {{(DATA_W-1){1'b0}}, b};
  endfunction : bitWord
endpackage : lim_pkg

// ---- rtl/limit_pair.sv ----
// One programmable high and low limit pair and its window comparison.
// Assumes at most one of the two write strobes is high in a cycle.
`timescale 1ns/100ps
module limit_pair (
  input  logic                       mclk,
  input  logic                       sys_rst,
  input  logic                       wrUpper,
  input  logic                       wrLower,
  input  logic [lim_pkg::DATA_W-1:0] wrValue,
  input  logic [lim_pkg::DATA_W-1:0] sample,
  output logic [lim_pkg::DATA_W-1:0] upper,
  output logic [lim_pkg::DATA_W-1:0] lower,
  output logic                       outside,
  output logic                       refused
);
  typedef struct packed {
    logic [lim_pkg::DATA_W-1:0] upper;
    logic [lim_pkg::DATA_W-1:0] lower;
  } pair_t;

  pair_t q;
  pair_t d;

  always_comb begin
    d = q;
    refused = (wrUpper && (wrValue < q.lower)) || (wrLower && (wrValue > q.upper));
    if (wrUpper && !refused) begin
      d.upper = wrValue;
    end
    if (wrLower && !refused) begin
      d.lower = wrValue;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '{upper: lim_pkg::LIMIT_UPPER_RESET, lower: lim_pkg::LIMIT_LOWER_RESET};
    end else begin
      q <= d;
    end
  end

  assign upper = q.upper;
  assign lower = q.lower;
  // Both limits count as inside.
  assign outside = (sample < q.lower) || (sample > q.upper);

  property p_orderedPair;
    @(posedge mclk) disable iff (sys_rst) q.lower <= q.upper;
  endproperty
  a_orderedPair: assert property (p_orderedPair)
    else $error("Lower limit above upper limit.");

  property p_refusedKeeps;
    @(posedge mclk) disable iff (sys_rst) refused |=> $stable(q);
  endproperty
  a_refusedKeeps: assert property (p_refusedKeeps)
    else $error("Refused limit write changed the pair.");
endmodule : limit_pair

// ---- rtl/sticky_flags.sv ----
// A row of sticky event flags that a single clear strobe zeroes.
// Assumes events are one-cycle or level inputs on the same clock.
`timescale 1ns/100ps
module sticky_flags #(
  parameter int W = 4
) (
  input  logic         mclk,
  input  logic         sys_rst,
  input  logic [W-1:0] setEvent,
  input  logic         clear,
  output logic [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } flag_state_t;

  flag_state_t q;
  flag_state_t d;

  // An event in the clearing cycle survives the clear.
  always_comb begin
    d.flags = (clear ? '0 : q.flags) | setEvent;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign flags = q.flags;

  property p_flagsHold;
    @(posedge mclk) disable iff (sys_rst) !clear |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_flagsHold: assert property (p_flagsHold)
    else $error("Flag dropped without a clear.");

  property p_clearZeroes;
    @(posedge mclk) disable iff (sys_rst) (clear && (setEvent == '0)) |=> (flags == '0);
  endproperty
  a_clearZeroes: assert property (p_clearZeroes)
    else $error("Clear left a flag set.");
endmodule : sticky_flags

// ---- rtl/load_limit_status.sv ----
// Limit checking, no-good flag and status readback for one electronic load module.
// Assumes parsed host commands and measurement samples arrive as one-cycle valid words.
`timescale 1ns/100ps
module load_limit_status (
  input  logic                       mclk,
  input  logic                       sys_rst,
  input  lim_pkg::cmd_t              cmd,
  input  lim_pkg::meas_t             meas,
  input  logic [3:0]                 channelErrorEvent,
  input  logic                       overPowerTrip,
  input  logic                       overTemperatureTrip,
  input  logic                       overVoltageTrip,
  input  logic                       overCurrentTrip,
  output lim_pkg::rsp_t              rsp,
  output logic                       noGoodLed,
  output logic                       loadEnable,
  output logic                       shortTestActive,
  output logic                       currentRangePrecise,
  output logic [lim_pkg::DATA_W-1:0] dimmingFrequency,
  output logic [lim_pkg::DUTY_W-1:0] dimmingDuty
);
  typedef struct packed {
    logic                       loadOn;
    lim_pkg::mode_t             mode;
    logic                       shortActive;
    logic                       presetOn;
    lim_pkg::sense_t            sense;
    logic                       levelHigh;
    logic                       staticOp;
    logic                       rangeAuto;
    logic                       rangePrecise;
    logic [lim_pkg::DATA_W-1:0] frequency;
    logic [lim_pkg::DUTY_W-1:0] duty;
    logic [lim_pkg::DUTY_W-1:0] dutyOut;
    logic                       noGood;
    lim_pkg::rsp_t              rsp;
  } state_t;

  state_t q;
  state_t d;

  logic [lim_pkg::LIMIT_N-1:0]  wrUpper;
  logic [lim_pkg::LIMIT_N-1:0]  wrLower;
  logic [lim_pkg::LIMIT_N-1:0]  outside;
  logic [lim_pkg::LIMIT_N-1:0]  pairRefused;
  logic [lim_pkg::DATA_W-1:0]   sample [lim_pkg::LIMIT_N];
  logic [lim_pkg::DATA_W-1:0]   upper [lim_pkg::LIMIT_N];
  logic [lim_pkg::DATA_W-1:0]   lower [lim_pkg::LIMIT_N];
  logic [lim_pkg::ERROR_W-1:0]  errorFlags;
  logic [lim_pkg::PROTECTION_FLAGS_W-1:0]   protectionFlags;
  logic [lim_pkg::ERROR_W-1:0]  errorEvent;
  logic [lim_pkg::PROTECTION_FLAGS_W-1:0]   protectionEvent;
  logic                         clearFlagsCommand;
  logic                         setRefused;
  logic                         commandError;
  logic                         currentChecked;
  logic                         powerChecked;
  logic                         voltageOutside;

  // The short-test pair watches the same voltage as the normal pair.
  assign sample[lim_pkg::LIM_CURRENT] = meas.current;
  assign sample[lim_pkg::LIM_POWER] = meas.power;
  assign sample[lim_pkg::LIM_VOLTAGE] = meas.voltage;
  assign sample[lim_pkg::LIM_SHORT_VOLTAGE] = meas.voltage;

  for (genvar i = 0; i < lim_pkg::LIMIT_N; i++) begin : g_pair
    assign wrUpper[i] = lim_pkg::isOp(cmd, lim_pkg::OP_SET_UPPER) && (cmd.sel == i);
    assign wrLower[i] = lim_pkg::isOp(cmd, lim_pkg::OP_SET_LOWER) && (cmd.sel == i);

    limit_pair u_pair (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .wrUpper (wrUpper[i]),
      .wrLower (wrLower[i]),
      .wrValue (cmd.value),
      .sample  (sample[i]),
      .upper   (upper[i]),
      .lower   (lower[i]),
      .outside (outside[i]),
      .refused (pairRefused[i])
    );
  end

  assign clearFlagsCommand = lim_pkg::isOp(cmd, lim_pkg::OP_CLEAR);

  always_comb begin
    errorEvent = '0;
    errorEvent[lim_pkg::ERR_OPERATION_BIT-1:0] = channelErrorEvent;
    errorEvent[lim_pkg::ERR_OPERATION_BIT] = setRefused;
    errorEvent[lim_pkg::ERR_COMMAND_BIT] = commandError;
    protectionEvent = '0;
    protectionEvent[lim_pkg::PROTECTION_FLAGS_POWER_BIT] = overPowerTrip;
    protectionEvent[lim_pkg::PROTECTION_FLAGS_TEMPERATURE_BIT] = overTemperatureTrip;
    protectionEvent[lim_pkg::PROTECTION_FLAGS_VOLTAGE_BIT] = overVoltageTrip;
    protectionEvent[lim_pkg::PROTECTION_FLAGS_CURRENT_BIT] = overCurrentTrip;
  end

  sticky_flags #(
    .W (lim_pkg::ERROR_W)
  ) u_error (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .setEvent (errorEvent),
    .clear    (clearFlagsCommand),
    .flags    (errorFlags)
  );

  sticky_flags #(
    .W (lim_pkg::PROTECTION_FLAGS_W)
  ) u_protection (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .setEvent (protectionEvent),
    .clear    (clearFlagsCommand),
    .flags    (protectionFlags)
  );

  // Which limit pairs apply in the present mode and test state.
  always_comb begin
    currentChecked = (q.mode == lim_pkg::MODE_CONSTANT_CURRENT) ||
                     (q.mode == lim_pkg::MODE_CONSTANT_RESISTANCE);
    powerChecked = (q.mode == lim_pkg::MODE_CONSTANT_POWER) ||
                   (q.mode == lim_pkg::MODE_CONSTANT_RESISTANCE);
    voltageOutside = q.shortActive ? outside[lim_pkg::LIM_SHORT_VOLTAGE]
                                   : outside[lim_pkg::LIM_VOLTAGE];
  end

  always_comb begin
    d = q;
    d.rsp = '0;
    setRefused = 1'b0;
    commandError = 1'b0;
    if (meas.valid) begin
      d.noGood = (currentChecked && outside[lim_pkg::LIM_CURRENT]) ||
                 (powerChecked && outside[lim_pkg::LIM_POWER]) ||
                 voltageOutside;
    end
    if (!q.rangeAuto) begin
      d.rangePrecise = 1'b0;
    end else if (meas.valid) begin
      d.rangePrecise = meas.current < lim_pkg::RANGE_PRECISE_BELOW;
    end
    if (cmd.valid) begin
      d.rsp.valid = 1'b1;
      unique case (cmd.op)
        lim_pkg::OP_SET_LOAD: begin
          d.loadOn = cmd.value[0];
        end
        lim_pkg::OP_SET_MODE: begin
          if (cmd.value > lim_pkg::DATA_W'(lim_pkg::MODE_LED_SIMULATION)) begin
            setRefused = 1'b1;
          end else begin
            d.mode = lim_pkg::mode_t'(cmd.value[2:0]);
          end
        end
        lim_pkg::OP_SET_SHORT: begin
          d.shortActive = cmd.value[0];
        end
        lim_pkg::OP_SET_PRESET: begin
          d.presetOn = cmd.value[0];
        end
        lim_pkg::OP_SET_SENSE: begin
          if (cmd.value > lim_pkg::DATA_W'(lim_pkg::SENSE_AUTO)) begin
            setRefused = 1'b1;
          end else begin
            d.sense = lim_pkg::sense_t'(cmd.value[1:0]);
          end
        end
        lim_pkg::OP_SET_LEVEL: begin
          d.levelHigh = cmd.value[0];
        end
        lim_pkg::OP_SET_DYNAMIC: begin
          d.staticOp = !cmd.value[0];
        end
        lim_pkg::OP_SET_RANGE: begin
          d.rangeAuto = cmd.value[0];
        end
        lim_pkg::OP_SET_FREQUENCY: begin
          d.frequency = cmd.value;
        end
        lim_pkg::OP_SET_DUTY: begin
          if ((q.frequency == lim_pkg::DIMMING_FREQUENCY_DC) ||
              (cmd.value < lim_pkg::DATA_W'(lim_pkg::DUTY_MIN)) ||
              (cmd.value > lim_pkg::DATA_W'(lim_pkg::DUTY_MAX))) begin
            setRefused = 1'b1;
          end else begin
            d.duty = cmd.value[lim_pkg::DUTY_W-1:0];
          end
        end
        lim_pkg::OP_SET_UPPER, lim_pkg::OP_SET_LOWER: begin
          setRefused = |pairRefused;
        end
        lim_pkg::OP_CLEAR: begin
          d.rsp.data = '0;
        end
        lim_pkg::OP_GET_LOAD: begin
          d.rsp.data = lim_pkg::bitWord(q.loadOn);
        end
        lim_pkg::OP_GET_MODE: begin
          d.rsp.data = lim_pkg::DATA_W'(q.mode);
        end
        lim_pkg::OP_GET_SHORT: begin
          d.rsp.data = lim_pkg::bitWord(!q.shortActive);
        end
        lim_pkg::OP_GET_PRESET: begin
          d.rsp.data = lim_pkg::bitWord(q.presetOn);
        end
        lim_pkg::OP_GET_SENSE: begin
          d.rsp.data = lim_pkg::bitWord(q.sense == lim_pkg::SENSE_ON);
        end
        lim_pkg::OP_GET_LEVEL: begin
          d.rsp.data = lim_pkg::bitWord(q.levelHigh);
        end
        lim_pkg::OP_GET_DYNAMIC: begin
          d.rsp.data = lim_pkg::bitWord(q.staticOp);
        end
        lim_pkg::OP_GET_FREQUENCY: begin
          d.rsp.data = q.frequency;
        end
        lim_pkg::OP_GET_DUTY: begin
          d.rsp.data = lim_pkg::DATA_W'(q.duty);
        end
        lim_pkg::OP_GET_UPPER: begin
          d.rsp.data = upper[cmd.sel];
        end
        lim_pkg::OP_GET_LOWER: begin
          d.rsp.data = lower[cmd.sel];
        end
        lim_pkg::OP_GET_ERROR: begin
          d.rsp.data = lim_pkg::DATA_W'(errorFlags);
        end
        lim_pkg::OP_GET_PROTECTION: begin
          d.rsp.data = lim_pkg::DATA_W'(protectionFlags);
        end
        lim_pkg::OP_GET_NO_GOOD: begin
          d.rsp.data = lim_pkg::bitWord(q.noGood);
        end
        default: begin
          commandError = 1'b1;
        end
      endcase
      d.rsp.refused = setRefused || commandError;
    end
    // A DC dimming frequency keeps every duty value from taking effect.
    d.dutyOut = (d.frequency == lim_pkg::DIMMING_FREQUENCY_DC) ? '0 : d.duty;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '{loadOn: 1'b0,
             mode: lim_pkg::MODE_CONSTANT_CURRENT,
             shortActive: 1'b0,
             presetOn: 1'b0,
             sense: lim_pkg::SENSE_OFF,
             levelHigh: 1'b0,
             staticOp: 1'b1,
             rangeAuto: 1'b1,
             rangePrecise: 1'b0,
             frequency: lim_pkg::DIMMING_FREQUENCY_RESET,
             duty: lim_pkg::DUTY_RESET,
             dutyOut: '0,
             noGood: 1'b0,
             rsp: '0};
    end else begin
      q <= d;
    end
  end

  assign rsp = q.rsp;
  assign noGoodLed = q.noGood;
  assign loadEnable = q.loadOn;
  assign shortTestActive = q.shortActive;
  assign currentRangePrecise = q.rangePrecise;
  assign dimmingFrequency = q.frequency;
  assign dimmingDuty = q.dutyOut;

  property p_dutyRange;
    @(posedge mclk) disable iff (sys_rst)
      (q.duty >= lim_pkg::DUTY_MIN) && (q.duty <= lim_pkg::DUTY_MAX);
  endproperty
  a_dutyRange: assert property (p_dutyRange)
    else $error("Stored duty outside its range.");

  property p_dutyAtDc;
    @(posedge mclk) disable iff (sys_rst)
      (lim_pkg::isOp(cmd, lim_pkg::OP_SET_DUTY) && (q.frequency == lim_pkg::DIMMING_FREQUENCY_DC))
      |=> (rsp.refused && $stable(q.duty) && (dimmingDuty == '0));
  endproperty
  a_dutyAtDc: assert property (p_dutyAtDc)
    else $error("Duty accepted at DC frequency.");

  property p_currentNoGood;
    @(posedge mclk) disable iff (sys_rst)
      (meas.valid && outside[lim_pkg::LIM_CURRENT] &&
       (q.mode == lim_pkg::MODE_CONSTANT_CURRENT)) |=> noGoodLed;
  endproperty
  a_currentNoGood: assert property (p_currentNoGood)
    else $error("Current outside limits without no-good.");

  property p_powerNoGood;
    @(posedge mclk) disable iff (sys_rst)
      (meas.valid && outside[lim_pkg::LIM_POWER] &&
       (q.mode == lim_pkg::MODE_CONSTANT_POWER)) |=> noGoodLed;
  endproperty
  a_powerNoGood: assert property (p_powerNoGood)
    else $error("Power outside limits without no-good.");

  property p_shortNoGood;
    @(posedge mclk) disable iff (sys_rst)
      (meas.valid && q.shortActive && outside[lim_pkg::LIM_SHORT_VOLTAGE]) |=> noGoodLed;
  endproperty
  a_shortNoGood: assert property (p_shortNoGood)
    else $error("Short-test voltage outside limits without no-good.");

  property p_insideGood;
    @(posedge mclk) disable iff (sys_rst)
      (meas.valid && (outside == '0)) |=> !noGoodLed;
  endproperty
  a_insideGood: assert property (p_insideGood)
    else $error("No-good raised with every quantity inside.");

  property p_modeReadback;
    @(posedge mclk) disable iff (sys_rst)
      lim_pkg::isOp(cmd, lim_pkg::OP_GET_MODE)
      |=> (rsp.valid && (rsp.data == lim_pkg::DATA_W'($past(q.mode))));
  endproperty
  a_modeReadback: assert property (p_modeReadback)
    else $error("Mode readback wrong.");

  property p_shortReadback;
    @(posedge mclk) disable iff (sys_rst)
      lim_pkg::isOp(cmd, lim_pkg::OP_GET_SHORT) |=> (rsp.data[0] == !shortTestActive);
  endproperty
  a_shortReadback: assert property (p_shortReadback)
    else $error("Short status readback wrong.");

  property p_senseReadback;
    @(posedge mclk) disable iff (sys_rst)
      lim_pkg::isOp(cmd, lim_pkg::OP_GET_SENSE)
      |=> (rsp.data[0] == ($past(q.sense) == lim_pkg::SENSE_ON));
  endproperty
  a_senseReadback: assert property (p_senseReadback)
    else $error("Sense readback wrong.");

  property p_noGoodQuery;
    @(posedge mclk) disable iff (sys_rst)
      lim_pkg::isOp(cmd, lim_pkg::OP_GET_NO_GOOD) |=> (rsp.data[0] == $past(noGoodLed));
  endproperty
  a_noGoodQuery: assert property (p_noGoodQuery)
    else $error("No-good query disagrees with the indicator.");

  property p_forcedRange;
    @(posedge mclk) disable iff (sys_rst)
      (!q.rangeAuto && !$past(q.rangeAuto)) |-> !currentRangePrecise;
  endproperty
  a_forcedRange: assert property (p_forcedRange)
    else $error("Precise range used while forced to the second range.");
endmodule : load_limit_status

// ---- verif/host_model.sv ----
// Host model: issues parsed commands one at a time and collects each answer.
// Assumes the block answers exactly one clock after it takes a command.
`timescale 1ns/100ps
module host_model (
  input  logic          mclk,
  input  lim_pkg::rsp_t rsp,
  output lim_pkg::cmd_t cmd
);
  initial cmd = '0;
  // Holds the command over exactly one taking edge, then reads the answer.
  task automatic send(input lim_pkg::op_t op, input int sel, input int val,
                      output lim_pkg::rsp_t r);
    @(posedge mclk);
    #1;
    cmd = '{1'b1, op, lim_pkg::limit_sel_t'(sel), 16'(val)};
    @(posedge mclk);
    #1;
    cmd.valid = 1'b0;
    r = rsp;
  endtask : send
endmodule : host_model

// ---- verif/load_limit_status_tb_top.sv ----
// Self-checking bench for the load limit and status block.
// Assumes host_model drives the command port and one 100 MHz clock.
`timescale 1ns/100ps
module load_limit_status_tb_top;
  logic           mclk = 1'b0;
  logic           sys_rst = 1'b1;
  lim_pkg::cmd_t  cmd;
  lim_pkg::meas_t meas = '0;
  lim_pkg::rsp_t  rsp;
  lim_pkg::rsp_t  r;
  logic [3:0]     chErr = 4'h0;
  logic [3:0]     trip = 4'h0;
  logic           noGood;
  logic           loadOn;
  logic           shortOn;
  logic           precise;
  logic [15:0]    dimming_frequency;
  logic [6:0]     duty;
  int             miscompares = 0;
  int             checksDone = 0;

  always #5 mclk = ~mclk;
  host_model host (.mclk(mclk), .rsp(rsp), .cmd(cmd));
  load_limit_status uut (.mclk(mclk), .sys_rst(sys_rst), .cmd(cmd), .meas(meas),
    .channelErrorEvent(chErr), .overPowerTrip(trip[0]), .overTemperatureTrip(trip[1]),
    .overVoltageTrip(trip[2]), .overCurrentTrip(trip[3]), .rsp(rsp), .noGoodLed(noGood),
    .loadEnable(loadOn), .shortTestActive(shortOn), .currentRangePrecise(precise),
    .dimmingFrequency(dimming_frequency), .dimmingDuty(duty));

  task automatic chk(input string nm, input int e, input logic [17:0] g);
    checksDone++;
    if (g !== 18'(e)) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic run(input lim_pkg::op_t op, input int sel, val, rf, d, input string nm);
    host.send(op, sel, val, r);
    chk(nm, 'h20000 + rf * 'h10000 + d, {r.valid, r.refused, r.data});
  endtask : run

  task automatic rb(input lim_pkg::op_t s, g, input int v, e);
    run(s, 0, v, 0, 0, "set");
    run(g, 0, 0, 0, e, "get");
  endtask : rb

  // Sends one measurement and judges the no-good level it leaves behind.
  task automatic samp(input int c, p, v, ng);
    @(posedge mclk);
    #1;
    meas = '{1'b1, 16'(c), 16'(p), 16'(v)};
    @(posedge mclk);
    #1;
    meas.valid = 1'b0;
    chk("noGood", ng, {17'h0, noGood});
  endtask : samp

  // Holds the event inputs high over exactly one clock edge.
  task automatic pulse(input logic [3:0] ce, tp);
    @(posedge mclk);
    #1;
    chErr = ce;
    trip = tp;
    @(posedge mclk);
    #1;
    chErr = 4'h0;
    trip = 4'h0;
  endtask : pulse

  task automatic tModes;
    for (int m = 0; m < 5; m++) begin
      rb(lim_pkg::OP_SET_MODE, lim_pkg::OP_GET_MODE, m, m);
    end
    run(lim_pkg::OP_SET_MODE, 0, 5, 1, 0, "badMode");
  endtask : tModes

  task automatic tBools;
    rb(lim_pkg::OP_SET_LOAD, lim_pkg::OP_GET_LOAD, 1, 1);
    chk("loadOn", 1, {17'h0, loadOn});
    rb(lim_pkg::OP_SET_LOAD, lim_pkg::OP_GET_LOAD, 0, 0);
    rb(lim_pkg::OP_SET_SHORT, lim_pkg::OP_GET_SHORT, 1, 0);
    rb(lim_pkg::OP_SET_SHORT, lim_pkg::OP_GET_SHORT, 0, 1);
    rb(lim_pkg::OP_SET_PRESET, lim_pkg::OP_GET_PRESET, 1, 1);
    rb(lim_pkg::OP_SET_PRESET, lim_pkg::OP_GET_PRESET, 0, 0);
    for (int s = 0; s < 3; s++) begin
      rb(lim_pkg::OP_SET_SENSE, lim_pkg::OP_GET_SENSE, s, s == 1);
    end
    rb(lim_pkg::OP_SET_LEVEL, lim_pkg::OP_GET_LEVEL, 1, 1);
    rb(lim_pkg::OP_SET_LEVEL, lim_pkg::OP_GET_LEVEL, 0, 0);
    rb(lim_pkg::OP_SET_DYNAMIC, lim_pkg::OP_GET_DYNAMIC, 1, 0);
    rb(lim_pkg::OP_SET_DYNAMIC, lim_pkg::OP_GET_DYNAMIC, 0, 1);
  endtask : tBools

  task automatic tLimits;
    run(lim_pkg::OP_SET_MODE, 0, 0, 0, 0, "cc");
    run(lim_pkg::OP_SET_UPPER, 0, 100, 0, 0, "iHi");
    run(lim_pkg::OP_SET_LOWER, 0, 10, 0, 0, "iLo");
    run(lim_pkg::OP_SET_LOWER, 0, 101, 1, 0, "iLoBad");
    run(lim_pkg::OP_GET_LOWER, 0, 0, 0, 10, "iLoKept");
    samp(100, 0, 0, 0);
    samp(10, 0, 0, 0);
    samp(101, 0, 0, 1);
    run(lim_pkg::OP_GET_NO_GOOD, 0, 0, 0, 1, "ngQuery");
    samp(9, 0, 0, 1);
    run(lim_pkg::OP_SET_UPPER, 1, 50, 0, 0, "pHi");
    samp(50, 60, 0, 0);
    run(lim_pkg::OP_SET_MODE, 0, 3, 0, 0, "cp");
    samp(5, 60, 0, 1);
    samp(5, 50, 0, 0);
    run(lim_pkg::OP_GET_NO_GOOD, 0, 0, 0, 0, "ngQuery");
    run(lim_pkg::OP_SET_MODE, 0, 1, 0, 0, "cr");
    samp(5, 50, 0, 1);
    run(lim_pkg::OP_SET_MODE, 0, 2, 0, 0, "cv");
    run(lim_pkg::OP_SET_UPPER, 2, 200, 0, 0, "vHi");
    run(lim_pkg::OP_SET_LOWER, 2, 20, 0, 0, "vLo");
    run(lim_pkg::OP_SET_UPPER, 2, 19, 1, 0, "vHiBad");
    run(lim_pkg::OP_GET_UPPER, 2, 0, 0, 200, "vHiKept");
    samp(5, 60, 201, 1);
    samp(5, 60, 19, 1);
    samp(5, 60, 20, 0);
    run(lim_pkg::OP_SET_UPPER, 3, 300, 0, 0, "sHi");
    run(lim_pkg::OP_SET_LOWER, 3, 250, 0, 0, "sLo");
    run(lim_pkg::OP_SET_SHORT, 0, 1, 0, 0, "shortOn");
    chk("shortOn", 1, {17'h0, shortOn});
    samp(5, 60, 260, 0);
    samp(5, 60, 200, 1);
    run(lim_pkg::OP_SET_SHORT, 0, 0, 0, 0, "shortOff");
  endtask : tLimits

  task automatic tDutyRange;
    run(lim_pkg::OP_SET_DUTY, 0, 50, 1, 0, "dutyDc");
    chk("duty", 0, {11'h0, duty});
    run(lim_pkg::OP_SET_FREQUENCY, 0, 100, 0, 0, "dimming_frequency");
    chk("dimming_frequency", 100, {2'h0, dimming_frequency});
    run(lim_pkg::OP_GET_FREQUENCY, 0, 0, 0, 100, "freqGet");
    run(lim_pkg::OP_SET_DUTY, 0, 0, 1, 0, "duty0");
    run(lim_pkg::OP_SET_DUTY, 0, 100, 1, 0, "duty100");
    run(lim_pkg::OP_SET_DUTY, 0, 1, 0, 0, "duty1");
    chk("duty", 1, {11'h0, duty});
    run(lim_pkg::OP_SET_DUTY, 0, 99, 0, 0, "duty99");
    chk("duty", 99, {11'h0, duty});
    run(lim_pkg::OP_GET_DUTY, 0, 0, 0, 99, "dutyGet");
    samp(16'h0FFF, 0, 100, 0);
    chk("precise", 1, {17'h0, precise});
    samp(16'h1000, 0, 100, 0);
    chk("precise", 0, {17'h0, precise});
    run(lim_pkg::OP_SET_RANGE, 0, 0, 0, 0, "forced");
    samp(1, 0, 100, 0);
    chk("precise", 0, {17'h0, precise});
    run(lim_pkg::OP_SET_FREQUENCY, 0, 0, 0, 0, "freqDc");
    chk("duty", 0, {11'h0, duty});
    run(lim_pkg::OP_GET_DUTY, 0, 0, 0, 99, "dutyKept");
  endtask : tDutyRange

  task automatic tFlags;
    run(lim_pkg::OP_CLEAR, 0, 0, 0, 0, "clear");
    run(lim_pkg::OP_GET_ERROR, 0, 0, 0, 0, "err");
    pulse(4'hA, 4'h5);
    run(lim_pkg::OP_GET_PROTECTION, 0, 0, 0, 5, "protection_flags");
    run(lim_pkg::op_t'(5'h1F), 0, 0, 1, 0, "unknownOp");
    run(lim_pkg::OP_SET_MODE, 0, 7, 1, 0, "badMode");
    run(lim_pkg::OP_GET_ERROR, 0, 0, 0, 'h3A, "err");
    pulse(4'h5, 4'hA);
    run(lim_pkg::OP_GET_ERROR, 0, 0, 0, 'h3F, "err");
    run(lim_pkg::OP_GET_PROTECTION, 0, 0, 0, 'hF, "protection_flags");
    run(lim_pkg::OP_CLEAR, 0, 0, 0, 0, "clear");
    run(lim_pkg::OP_GET_ERROR, 0, 0, 0, 0, "err");
    run(lim_pkg::OP_GET_PROTECTION, 0, 0, 0, 0, "protection_flags");
  endtask : tFlags

  task automatic print_verdict;
    if (miscompares == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    chk("resetOuts", 0, {loadOn, shortOn, noGood, precise, duty, 7'h0});
    tModes();
    tBools();
    tLimits();
    tDutyRange();
    tFlags();
    print_verdict();
  end
endmodule : load_limit_status_tb_top
